//--- src/routing_pkg.sv
/*
 * Shared constants of the output routing block: register offsets, field
 * positions, reset values and the pin source selections.
 * Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
 */
package routing_pkg;

	// ==========================================================================
	// Register map (byte addresses)
	localparam logic [3:0] ADDR_ROUTE_SEL = 4'h0;
	localparam logic [3:0] ADDR_LOCAL_VAL = 4'h4;
	localparam logic [3:0] ADDR_CLK_DIV = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;

	// ==========================================================================
	// Source selection codes, two bits per pin in ROUTE_SEL
	typedef enum logic [1:0] {
		SRC_LOCAL = 2'b00,
		SRC_REMOTE = 2'b01,
		SRC_CLOCK = 2'b10,
		SRC_SPARE = 2'b11
	} pin_src_t;

	localparam int PIN_COUNT = 4;
	localparam int SEL_WIDTH = 2;
	localparam int AUX_OUT_PIN = 2;
	localparam int AUX_IN_PIN = 3;

	// ==========================================================================
	// Reset values
	localparam logic [7:0] ROUTE_SEL_RESET = 8'h00;
	localparam logic [3:0] LOCAL_VAL_RESET = 4'h0;
	localparam logic [7:0] CLK_DIV_RESET = 8'h01;

	// ==========================================================================
	// STATUS fields
	localparam int ST_REMOTE_LSB = 0;
	localparam int ST_MODE_BIT = 4;
	localparam int ST_PD_BIT = 5;
	localparam int ST_RES_BIT = 6;
	localparam int ST_AUX_CLOCK_INPUT_BIT = 7;
	localparam int ST_ADDR_LSB = 8;
	localparam int ST_EDGES_LSB = 16;

	// ==========================================================================
	// Strap decode and synchroniser layout
	localparam int STRAP_WIDTH = 3;
	localparam logic [6:0] I2C_ADDR_BASE = 7'h58;
	localparam int SYNC_WIDTH = 10;
	localparam int SY_REMOTE_LSB = 0;
	localparam int SY_PD_BIT = 4;
	localparam int SY_MODE_BIT = 5;
	localparam int SY_ADDR_LSB = 6;
	localparam int SY_AUX_CLOCK_INPUT_BIT = 9;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

//--- src/reg_access_if.sv
/*
 * Carrier between the AXI4-Lite slave and the register file of the routing
 * block. Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface reg_access_if;
	logic wr_en;
	logic [3:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_en;
	logic [3:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;

	modport bus (
		output wr_en,
		output wr_addr,
		output wr_data,
		output wr_strb,
		input wr_ok,
		output rd_en,
		output rd_addr,
		input rd_data,
		input rd_ok
	);

	modport regs (
		input wr_en,
		input wr_addr,
		input wr_data,
		input wr_strb,
		output wr_ok,
		input rd_en,
		input rd_addr,
		output rd_data,
		output rd_ok
	);
endinterface

//--- src/pin_sync.sv
/*
 * Three-stage synchroniser for inputs from outside the clock domain.
 * A change is accepted once the second and third stages agree.
 * Assumes a synchronous active-low reset on aclk.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] stable
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] second;
	logic [WIDTH-1:0] third;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta[i] <= 1'b0;
					second[i] <= 1'b0;
					third[i] <= 1'b0;
					stable[i] <= 1'b0;
				end else begin
					meta[i] <= async_in[i];
					second[i] <= meta[i];
					third[i] <= second[i];
					if (second[i] == third[i]) begin
						stable[i] <= third[i];
					end
				end
			end
		end
	endgenerate
endmodule

//--- src/axil_slave.sv
/*
 * AXI4-Lite slave front end. Takes write address and data in either order,
 * hands one write and one read at a time to the register file through reg_access_if.
 * Assumes the register file answers ok/data combinationally.
 */
`timescale 1ns/1ps
module axil_slave
	import routing_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	reg_access_if.bus ra
);
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;

	// Each channel is taken at most once until the response is accepted.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	assign ra.wr_en = aw_held && w_held && !s_axi_bvalid;
	assign ra.wr_addr = aw_addr;
	assign ra.rd_en = s_axi_arvalid && s_axi_arready;
	assign ra.rd_addr = s_axi_araddr;

	// ==========================================================================
	// Write channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (ra.wr_en) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			ra.wr_data <= 32'h0000_0000;
			ra.wr_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			ra.wr_data <= s_axi_wdata;
			ra.wr_strb <= s_axi_wstrb;
		end else if (ra.wr_en) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ra.wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= ra.wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================================
	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ra.rd_en) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= ra.rd_data;
			s_axi_rresp <= ra.rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

//--- src/serializer_output_routing_ctrl.sv
/*
 * Pin-level routing of the four general output pins of a video serializer,
 * power-down handling and strap capture, with an AXI4-Lite register file.
 * Assumes one 40 MHz clock; pins, remote levels and straps are asynchronous.
 */
// What this block does
// - Pins 0 and 1 each drive either the mirrored remote level or a local register bit.
// - Pin 2 mirrors the remote level or a local bit, or drives the output clock in oscillator mode.
// - Pin 3 mirrors the remote level or a local bit, or becomes the clock input in oscillator mode.
// - While powerdown_n is high the block is enabled and works normally.
// - While powerdown_n is low the PLL is off, power is minimal and ROUTE_SEL, LOCAL_VAL and CLK_DIV go to defaults.
// - The mode strap chooses between the imager pixel clock and an external oscillator.
// - The address strap sets the device address answered on the I2C control bus.
`timescale 1ns/1ps
module serializer_output_routing_ctrl
	import routing_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] remote_gpio_level,
	input wire logic powerdown_n,
	input wire logic mode_strap,
	input wire logic [2:0] address_strap,
	input wire logic reserved_tie_low,
	output logic [2:0] general_output_pin,
	input wire logic general_output_pin3_in,
	output logic general_output_pin3_out,
	output logic general_output_pin3_oe,
	output logic pll_enable,
	output logic low_power,
	output logic ext_osc_mode,
	output logic [6:0] i2c_device_address
);
	reg_access_if ra();

	logic [SYNC_WIDTH-1:0] sync_raw;
	logic [SYNC_WIDTH-1:0] synced;
	logic cfg_rst;
	logic pd_active;
	logic strap_pending;
	logic [7:0] route_sel;
	logic [3:0] local_val;
	logic [7:0] clk_div;
	logic [7:0] div_count;
	logic div_tick;
	logic aux_clock_output;
	logic aux_clock_input;
	logic aux_clock_input_prev;
	logic [15:0] aux_clock_input_edges;
	logic reserved_seen;
	logic [3:0] next_pin;
	logic [3:0] remote_level;
	pin_src_t sel [PIN_COUNT];

	// ==========================================================================
	// Input synchronisation
	assign sync_raw = {general_output_pin3_in, address_strap, mode_strap, powerdown_n,
		remote_gpio_level};

	pin_sync #(
		.WIDTH(SYNC_WIDTH)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(sync_raw),
		.stable(synced)
	);

	assign remote_level = synced[SY_REMOTE_LSB +: PIN_COUNT];
	assign aux_clock_input = synced[SY_AUX_CLOCK_INPUT_BIT];

	// The synchroniser resets low, so the block starts powered down until the
	// pin has been seen high; this keeps the pins quiet through reset.
	assign pd_active = !synced[SY_PD_BIT];
	assign cfg_rst = !aresetn || pd_active;
	assign pll_enable = !pd_active;
	assign low_power = pd_active;

	// ==========================================================================
	// Strap capture
	// Straps are caught once, on the first cycle after reset or power-down
	// ends, so a strap that moves during operation changes nothing.
	always_ff @(posedge aclk) begin
		if (cfg_rst) begin
			strap_pending <= 1'b1;
		end else begin
			strap_pending <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_osc_mode <= 1'b0;
			i2c_device_address <= I2C_ADDR_BASE;
		end else if (strap_pending && !pd_active) begin
			ext_osc_mode <= synced[SY_MODE_BIT];
			i2c_device_address <= I2C_ADDR_BASE |
				{4'h0, synced[SY_ADDR_LSB +: STRAP_WIDTH]};
		end
	end

	// ==========================================================================
	// Register bus front end
	axil_slave u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.ra(ra)
	);

	// ==========================================================================
	// Write decode
	always_comb begin
		if (ra.wr_addr == ADDR_ROUTE_SEL) begin
			ra.wr_ok = 1'b1;
		end else if (ra.wr_addr == ADDR_LOCAL_VAL) begin
			ra.wr_ok = 1'b1;
		end else if (ra.wr_addr == ADDR_CLK_DIV) begin
			ra.wr_ok = 1'b1;
		end else if (ra.wr_addr == ADDR_STATUS) begin
			ra.wr_ok = 1'b1;
		end else begin
			ra.wr_ok = 1'b0;
		end
	end

	// Writes made while powered down are answered but not stored, since the
	// configuration is held at its defaults for as long as the pin is low.
	always_ff @(posedge aclk) begin
		if (cfg_rst) begin
			route_sel <= ROUTE_SEL_RESET;
		end else if (ra.wr_en && ra.wr_addr == ADDR_ROUTE_SEL && ra.wr_strb[0]) begin
			route_sel <= ra.wr_data[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (cfg_rst) begin
			local_val <= LOCAL_VAL_RESET;
		end else if (ra.wr_en && ra.wr_addr == ADDR_LOCAL_VAL && ra.wr_strb[0]) begin
			local_val <= ra.wr_data[3:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (cfg_rst) begin
			clk_div <= CLK_DIV_RESET;
		end else if (ra.wr_en && ra.wr_addr == ADDR_CLK_DIV && ra.wr_strb[0]) begin
			clk_div <= ra.wr_data[7:0];
		end
	end

	// ==========================================================================
	// Read decode
	always_comb begin
		ra.rd_ok = 1'b1;
		if (ra.rd_addr == ADDR_ROUTE_SEL) begin
			ra.rd_data = {24'h00_0000, route_sel};
		end else if (ra.rd_addr == ADDR_LOCAL_VAL) begin
			ra.rd_data = {28'h000_0000, local_val};
		end else if (ra.rd_addr == ADDR_CLK_DIV) begin
			ra.rd_data = {24'h00_0000, clk_div};
		end else if (ra.rd_addr == ADDR_STATUS) begin
			ra.rd_data = 32'h0000_0000;
			ra.rd_data[ST_REMOTE_LSB +: PIN_COUNT] = remote_level;
			ra.rd_data[ST_MODE_BIT] = ext_osc_mode;
			ra.rd_data[ST_PD_BIT] = pd_active;
			ra.rd_data[ST_RES_BIT] = reserved_seen;
			ra.rd_data[ST_AUX_CLOCK_INPUT_BIT] = aux_clock_input;
			ra.rd_data[ST_ADDR_LSB +: 7] = i2c_device_address;
			ra.rd_data[ST_EDGES_LSB +: 16] = aux_clock_input_edges;
		end else begin
			ra.rd_data = 32'h0000_0000;
			ra.rd_ok = 1'b0;
		end
	end

	// The reserved pin must be tied low; a high level is only reported. It comes
	// straight from a pin, so it gets its own synchroniser.
	pin_sync #(
		.WIDTH(1)
	) u_res_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(reserved_tie_low),
		.stable(reserved_seen)
	);

	// ==========================================================================
	// Output clock divider
	// The clock output toggles once per divider period, so its frequency is
	// the bus clock over twice (clk_div + 1).
	always_ff @(posedge aclk) begin
		if (cfg_rst) begin
			div_count <= 8'h00;
		end else if (div_count >= clk_div) begin
			div_count <= 8'h00;
		end else begin
			div_count <= div_count + 8'h01;
		end
	end

	assign div_tick = !cfg_rst && (div_count >= clk_div);

	always_ff @(posedge aclk) begin
		if (cfg_rst || !ext_osc_mode) begin
			aux_clock_output <= 1'b0;
		end else if (div_tick) begin
			aux_clock_output <= !aux_clock_output;
		end
	end

	// ==========================================================================
	// Clock input monitor
	always_ff @(posedge aclk) begin
		if (cfg_rst) begin
			aux_clock_input_prev <= 1'b0;
			aux_clock_input_edges <= 16'h0000;
		end else begin
			aux_clock_input_prev <= aux_clock_input;
			if (ext_osc_mode && sel[AUX_IN_PIN] == SRC_CLOCK &&
				aux_clock_input && !aux_clock_input_prev) begin
				aux_clock_input_edges <= aux_clock_input_edges + 16'h0001;
			end
		end
	end

	// ==========================================================================
	// Pin source selection
	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++) begin : g_pin
			assign sel[p] = pin_src_t'(route_sel[p*SEL_WIDTH +: SEL_WIDTH]);

			always_comb begin
				case (sel[p])
					SRC_REMOTE: next_pin[p] = remote_level[p];
					SRC_CLOCK: begin
						if (p == AUX_OUT_PIN && ext_osc_mode) begin
							next_pin[p] = aux_clock_output;
						end else begin
							next_pin[p] = local_val[p];
						end
					end
					default: next_pin[p] = local_val[p];
				endcase
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (cfg_rst) begin
			general_output_pin <= 3'b000;
			general_output_pin3_out <= 1'b0;
			general_output_pin3_oe <= 1'b0;
		end else begin
			general_output_pin <= next_pin[2:0];
			general_output_pin3_out <= next_pin[AUX_IN_PIN];
			general_output_pin3_oe <= !(ext_osc_mode && sel[AUX_IN_PIN] == SRC_CLOCK);
		end
	end
endmodule

//--- sim/routing_monitor.sv
/*
 * Port checker for the output routing block, bound to its top module.
 * Assumes one clock aclk and the synchronous active-low reset aresetn.
 */
`timescale 1ns/1ps
module routing_monitor
	import routing_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic powerdown_n,
	input wire logic [2:0] general_output_pin,
	input wire logic general_output_pin3_oe,
	input wire logic pll_enable,
	input wire logic low_power,
	input wire logic [6:0] i2c_device_address
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================
	// Power-down and straps
	a_power_pair:
	assert property (low_power == !pll_enable) else $error("low_power mismatch");
	a_pd_off:
	assert property (!powerdown_n [*5] |-> !pll_enable) else $error("pll still on");
	a_pd_wake:
	assert property (powerdown_n [*6] |-> pll_enable) else $error("pll not on");
	a_pd_pins_idle:
	assert property (!pll_enable [*2] |-> general_output_pin == 3'h0 && !general_output_pin3_oe)
		else $error("pins active in power-down");
	a_addr_base:
	assert property (i2c_device_address[6:3] == I2C_ADDR_BASE[6:3]) else $error("bad address");

	// ==========================================
	// Register bus
	a_b_hold:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_w_blocked:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw taken");
	a_ar_blocked:
	assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
	a_read_turn:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
	a_write_turn:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("no bvalid");
endmodule

bind serializer_output_routing_ctrl routing_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .powerdown_n,
	.general_output_pin, .general_output_pin3_oe, .pll_enable, .low_power, .i2c_device_address);

//--- sim/remote_deser_model.sv
/*
 * Far-side model: the paired deserializer's input levels and the external
 * oscillator that feeds pin 3. Assumes the bench picks the levels to send.
 */
`timescale 1ns/1ps
module remote_deser_model (
	input wire logic aclk,
	input wire logic osc_en,
	input wire logic [3:0] lvl_req,
	output logic [3:0] remote_gpio_level = 4'h0,
	output logic osc_clk = 1'b0
);
	// The oscillator is unrelated in phase to aclk and parks low when off.
	initial begin
		forever #35 osc_clk = osc_en ? ~osc_clk : 1'b0;
	end

	always @(posedge aclk) begin
		remote_gpio_level <= lvl_req;
	end
endmodule

//--- sim/serializer_output_routing_ctrl_test.sv
/*
 * Self-checking bench for the output routing block with an AXI4-Lite master.
 * Assumes the far-side model and the bound port checker.
 */
`timescale 1ns/1ps
module serializer_output_routing_ctrl_test;
	import routing_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, powerdown_n, mode_strap, osc_en, osc_clk, general_output_pin3_in;
	logic general_output_pin3_out, general_output_pin3_oe, pll_enable, low_power, ext_osc_mode;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, remote_gpio_level, lvl_req, loc, e;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [2:0] address_strap, general_output_pin;
	logic [6:0] i2c_device_address;
	logic [7:0] sel;
	int err_count, n_tests, cyc, seed, tgl;
	int mdl[4];

	// Pin 3 is shared: the oscillator drives it only while the block lets go.
	assign general_output_pin3_in = general_output_pin3_oe ? general_output_pin3_out : osc_clk;

	serializer_output_routing_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .remote_gpio_level,
		.powerdown_n, .mode_strap, .address_strap, .reserved_tie_low(1'b0),
		.general_output_pin, .general_output_pin3_in, .general_output_pin3_out,
		.general_output_pin3_oe, .pll_enable, .low_power, .ext_osc_mode, .i2c_device_address);

	remote_deser_model u_far (.aclk, .osc_en, .lvl_req, .remote_gpio_level, .osc_clk);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ==========================================
	// Checking and bus tasks
	task automatic finish_test;
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A random half of the accesses raise the response ready only once the
	// response stands, so the slave must hold it through a stall.
	task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw, w, late;
		aw = 1'b0;
		w = 1'b0;
		late = 1'($random(seed));
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !late;
		while (!(aw && w)) begin
			@(negedge aclk);
			if (s_axi_awready === 1'b1) aw = 1'b1;
			if (s_axi_wready === 1'b1) w = 1'b1;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		if (late) begin
			@(posedge aclk);
			s_axi_bready <= 1'b1;
		end
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
		logic late;
		late = 1'($random(seed));
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !late;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		if (late) begin
			@(posedge aclk);
			s_axi_rready <= 1'b1;
		end
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask

	task automatic rchk(input logic [3:0] a, input int exp);
		rd(a, d, r);
		check(d, 32'(exp));
		check(r, RESP_OKAY);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic do_reset(input logic m);
		aresetn <= 1'b0;
		powerdown_n <= 1'b0;
		mode_strap <= m;
		mdl = '{32'(ROUTE_SEL_RESET), 32'(LOCAL_VAL_RESET), 32'(CLK_DIV_RESET), 0};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end

	// ==========================================
	// Scenarios
	initial begin
		seed = 32'hf78c;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, powerdown_n, mode_strap, osc_en, lvl_req} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		address_strap = 3'($random(seed));
		@(posedge aclk);
		do_reset(1'b0);
		settle(6);
		check({pll_enable, low_power, general_output_pin}, 5'h08);
		@(posedge aclk);
		powerdown_n <= 1'b1;
		settle(10);
		check({pll_enable, ext_osc_mode}, 2'b10);
		check(i2c_device_address, I2C_ADDR_BASE | 7'(address_strap));
		rd(ADDR_STATUS, d, r);
		check({d[14:8], d[4]}, {I2C_ADDR_BASE | 7'(address_strap), 1'b0});
		for (int a = 0; a < 3; a++) rchk(4'(a * 4), mdl[a]);
		for (int k = 0; k < 8; k++) begin
			sel = 8'($random(seed));
			loc = 4'($random(seed));
			lvl_req <= 4'($random(seed));
			wr(ADDR_ROUTE_SEL, {24'h0, sel}, r);
			wr(ADDR_LOCAL_VAL, {28'h0, loc}, r);
			mdl[0] = sel;
			mdl[1] = loc;
			for (int i = 0; i < 4; i++) e[i] = (sel[2*i+:2] == 2'b01) ? lvl_req[i] : loc[i];
			settle(8);
			check({general_output_pin3_out, general_output_pin}, e);
			check(general_output_pin3_oe, 1'b1);
			rchk(ADDR_ROUTE_SEL, mdl[0]);
			rd(ADDR_STATUS, d, r);
			check(d[3:0], lvl_req);
		end
		wr(4'h2, 32'h5, r);
		check(r, RESP_SLVERR);
		rd(4'h6, d, r);
		check(d, 32'h0000_0000);
		check(r, RESP_SLVERR);
		powerdown_n <= 1'b0;
		settle(8);
		check({pll_enable, low_power, general_output_pin3_oe, general_output_pin}, 6'h10);
		rd(ADDR_STATUS, d, r);
		check(d[5], 1'b1);
		powerdown_n <= 1'b1;
		mdl = '{32'(ROUTE_SEL_RESET), 32'(LOCAL_VAL_RESET), 32'(CLK_DIV_RESET), 0};
		settle(10);
		for (int a = 0; a < 3; a++) rchk(4'(a * 4), mdl[a]);
		do_reset(1'b1);
		powerdown_n <= 1'b1;
		osc_en <= 1'b1;
		settle(10);
		check(ext_osc_mode, 1'b1);
		wr(ADDR_CLK_DIV, 32'h3, r);
		wr(ADDR_ROUTE_SEL, 32'ha0, r);
		settle(4);
		check(general_output_pin3_oe, 1'b0);
		// Divider 3 toggles every four cycles, so forty cycles give ten changes.
		tgl = 0;
		e[0] = general_output_pin[2];
		repeat (40) begin
			@(negedge aclk);
			if (general_output_pin[2] !== e[0]) tgl++;
			e[0] = general_output_pin[2];
		end
		check(tgl >= 9 && tgl <= 11, 1'b1);
		// The oscillator on pin 3 must have been counted as a clock input.
		rd(ADDR_STATUS, d, r);
		check(d[31:16] != 16'h0000, 1'b1);
		check(d[4], 1'b1);
		finish_test();
	end
endmodule
